// [hw/usb_ctrl_pkg.sv]
package usb_ctrl_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [5:0] OFS_BUS_ID = 6'h00;
    localparam logic [5:0] OFS_FRAME_LO = 6'h04;
    localparam logic [5:0] OFS_FRAME_HI = 6'h08;
    localparam logic [5:0] OFS_EP_BASE = 6'h0C;
    localparam int EP_STRIDE = 4;

    localparam int EP_COUNT = 7;
    localparam int BUS_ID_W = 7;
    localparam int FRAME_W = 11;
    localparam int EP_W = 5;

    // Endpoint setup field positions
    localparam int BIT_DIR_SEL = 4;
    localparam int BIT_OUT_EN = 3;
    localparam int BIT_IN_EN = 2;
    localparam int BIT_HALT = 1;
    localparam int BIT_ACK_EN = 0;

    // Values after reset, and the endpoint zero setup that software restores
    localparam logic [6:0] BUS_ID_RST = 7'h00;
    localparam logic [10:0] FRAME_RST = 11'h000;
    localparam logic [4:0] EP_RST = 5'h00;
    localparam logic [4:0] EP_ZERO_DEFAULT = 5'h0D;

    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SOF, TOK_SETUP} tok_t;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_STALL} hs_t;

endpackage

// [hw/ep_decide_if.sv]
`timescale 1ns/1ps
interface ep_decide_if
    import usb_ctrl_pkg::*;
#(
    parameter int N = EP_COUNT
);
    logic tok_valid;
    tok_t tok_kind;
    logic [6:0] tok_addr;
    logic [3:0] tok_endp;
    logic [6:0] bus_id;
    logic [4:0] ep_setup [N];
    logic accept;
    hs_t hs;

    modport policy (
        input tok_valid, tok_kind, tok_addr, tok_endp, bus_id, ep_setup,
        output accept, hs
    );
    modport ctrl (
        output tok_valid, tok_kind, tok_addr, tok_endp, bus_id, ep_setup,
        input accept, hs
    );
endinterface

// [hw/ep_policy.sv]
`timescale 1ns/1ps
module ep_policy
    import usb_ctrl_pkg::*;
#(
    parameter int N = EP_COUNT
)
(
    ep_decide_if.policy dec
);
    logic [N-1:0] halt_live;
    logic [N-1:0] ok_in;
    logic [N-1:0] ok_out;
    logic [N-1:0] ok_setup;
    logic [2:0] idx;
    logic hit;
    logic allowed;

    for (genvar i = 0; i < N; i++)
    begin : g_ep
        // Halt counts only on a live endpoint
        assign halt_live[i] = dec.ep_setup[i][BIT_HALT]
            & (dec.ep_setup[i][BIT_IN_EN] | dec.ep_setup[i][BIT_OUT_EN]);
        assign ok_in[i] = dec.ep_setup[i][BIT_IN_EN];
        assign ok_out[i] = dec.ep_setup[i][BIT_OUT_EN];
        assign ok_setup[i] = dec.ep_setup[i][BIT_IN_EN] & dec.ep_setup[i][BIT_OUT_EN]
            & ~dec.ep_setup[i][BIT_DIR_SEL];
    end

    assign idx = dec.tok_endp[2:0];
    // SOF carries no address; it never reaches an endpoint
    assign hit = dec.tok_valid && dec.tok_kind != TOK_SOF
        && dec.tok_addr == dec.bus_id && int'(dec.tok_endp) < N;

    always_comb
    begin
        case (dec.tok_kind)
            TOK_IN: allowed = ok_in[idx];
            TOK_OUT: allowed = ok_out[idx];
            TOK_SETUP: allowed = ok_setup[idx];
            default: allowed = 1'b0;
        endcase
    end

    always_comb
    begin
        dec.accept = 1'b0;
        dec.hs = HS_NONE;
        if (hit && halt_live[idx])
        begin
            dec.accept = 1'b1;
            dec.hs = HS_STALL;
        end
        else if (hit && allowed)
        begin
            dec.accept = 1'b1;
            dec.hs = dec.ep_setup[idx][BIT_ACK_EN] ? HS_ACK : HS_NONE;
        end
    end
endmodule

// [hw/usb_addr_frame_ep.sv]
// Function
// - Hold a 7-bit bus id; answer only tokens addressed to it.
// - Bus id returns to zero on module reset and on bus reset.
// - Frame index split: low byte bits 7..0, high byte bits 2..0.
// - Every start-of-frame token loads its frame number into the index.
// - One setup register for each of endpoints 0 to 6.
// - Both enables clear means endpoint disabled, direction bit ignored.
// - In enable only: accept only IN transactions.
// - Out enable only: accept only OUT transactions.
// - Both enables, direction clear: accept IN, OUT and SETUP.
// - Halt bit answers every access with STALL, overriding all else.
// - Halt bit honoured only while an enable bit is set.
// - Ack enable one sends handshakes; zero omits them.
`timescale 1ns/1ps
module usb_addr_frame_ep
    import usb_ctrl_pkg::*;
#(
    parameter int N = EP_COUNT
)
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic [5:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_TOKEN_VALID,
    input wire logic [1:0] I_TOKEN_KIND,
    input wire logic [6:0] I_TOKEN_ADDR,
    input wire logic [3:0] I_TOKEN_ENDP,
    input wire logic [10:0] I_TOKEN_FRAME,
    input wire logic I_BUS_RESET,
    output logic O_TOKEN_ACCEPT,
    output logic [1:0] O_HANDSHAKE,
    output logic [3:0] O_ACCEPT_ENDP,
    output logic [1:0] O_ACCEPT_KIND
);
    logic [6:0] bus_id_q;
    logic [10:0] frame_q;
    logic [4:0] ep_setup_q [N];
    logic ack_q;
    logic req;
    logic done;
    logic wr_en;
    logic [31:0] rd_d;
    logic [31:0] readdata_q;
    logic ep_hit;
    logic [5:0] ep_ofs;
    logic [2:0] ep_sel;
    tok_t tok_kind;
    logic accept_q;
    hs_t hs_q;
    logic [3:0] endp_q;
    tok_t kind_q;

    ep_decide_if #(.N(N)) dec ();

    ep_policy #(.N(N)) u_policy (
        .dec(dec.policy)
    );

    assign tok_kind = tok_t'(I_TOKEN_KIND);

    // Bus slave: one wait cycle, data sampled before release
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign done = req & ack_q;
    assign O_AVS_WAITREQUEST = req & ~ack_q;
    assign wr_en = I_AVS_WRITE & done & I_AVS_BYTEENABLE[0];
    assign O_AVS_READDATA = readdata_q;

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end

    assign ep_ofs = I_AVS_ADDRESS - OFS_EP_BASE;
    assign ep_sel = ep_ofs[4:2];
    // Misaligned or out of range addresses are unmapped
    assign ep_hit = I_AVS_ADDRESS >= OFS_EP_BASE
        && int'(ep_ofs) < N * EP_STRIDE
        && I_AVS_ADDRESS[1:0] == 2'b00;

    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (I_AVS_ADDRESS == OFS_BUS_ID)
        begin
            rd_d = {25'h000_0000, bus_id_q};
        end
        else if (I_AVS_ADDRESS == OFS_FRAME_LO)
        begin
            rd_d = {24'h00_0000, frame_q[7:0]};
        end
        else if (I_AVS_ADDRESS == OFS_FRAME_HI)
        begin
            rd_d = {29'h0000_0000, frame_q[10:8]};
        end
        else if (ep_hit)
        begin
            rd_d = {27'h000_0000, ep_setup_q[ep_sel]};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            readdata_q <= 32'h0000_0000;
        end
        else if (I_AVS_READ && !ack_q)
        begin
            readdata_q <= rd_d;
        end
    end

    // Bus reset beats a software write in the same cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            bus_id_q <= BUS_ID_RST;
        end
        else if (I_BUS_RESET)
        begin
            bus_id_q <= BUS_ID_RST;
        end
        else if (wr_en && I_AVS_ADDRESS == OFS_BUS_ID)
        begin
            bus_id_q <= I_AVS_WRITEDATA[6:0];
        end
    end

    // SOF is broadcast, so it loads regardless of the bus id
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            frame_q <= FRAME_RST;
        end
        else if (I_TOKEN_VALID && tok_kind == TOK_SOF)
        begin
            frame_q <= I_TOKEN_FRAME;
        end
    end

    // Endpoints also clear on bus reset; software restores endpoint zero
    for (genvar i = 0; i < N; i++)
    begin : g_ep_reg
        always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
        begin
            if (!I_RESET_N)
            begin
                ep_setup_q[i] <= EP_RST;
            end
            else if (I_BUS_RESET)
            begin
                ep_setup_q[i] <= EP_RST;
            end
            else if (wr_en && ep_hit && int'(ep_sel) == i)
            begin
                ep_setup_q[i] <= I_AVS_WRITEDATA[4:0];
            end
        end
        assign dec.ep_setup[i] = ep_setup_q[i];
    end

    assign dec.tok_valid = I_TOKEN_VALID;
    assign dec.tok_kind = tok_kind;
    assign dec.tok_addr = I_TOKEN_ADDR;
    assign dec.tok_endp = I_TOKEN_ENDP;
    assign dec.bus_id = bus_id_q;

    // Decision registered so the packet engine sees a clean pulse
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            accept_q <= 1'b0;
            hs_q <= HS_NONE;
        end
        else
        begin
            accept_q <= dec.accept;
            hs_q <= dec.hs;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            endp_q <= 4'h0;
            kind_q <= TOK_OUT;
        end
        else if (dec.accept)
        begin
            endp_q <= I_TOKEN_ENDP;
            kind_q <= tok_kind;
        end
    end

    assign O_TOKEN_ACCEPT = accept_q;
    assign O_HANDSHAKE = hs_q;
    assign O_ACCEPT_ENDP = endp_q;
    assign O_ACCEPT_KIND = kind_q;

    // Checking helpers
    logic tok_match;
    logic [4:0] sel_setup;
    logic sel_live;

    assign sel_setup = (int'(I_TOKEN_ENDP) < N) ? ep_setup_q[I_TOKEN_ENDP[2:0]] : EP_RST;
    assign sel_live = sel_setup[BIT_IN_EN] | sel_setup[BIT_OUT_EN];
    assign tok_match = I_TOKEN_VALID && tok_kind != TOK_SOF
        && I_TOKEN_ADDR == bus_id_q && int'(I_TOKEN_ENDP) < N;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    bus_reset_id_a: assert property (
        I_BUS_RESET |=> bus_id_q == BUS_ID_RST && !O_TOKEN_ACCEPT ##1 bus_id_q == BUS_ID_RST
            || $past(wr_en))
    else $error("bus id not cleared by bus reset");

    id_match_a: assert property (
        O_TOKEN_ACCEPT |-> $past(I_TOKEN_ADDR) == $past(bus_id_q) && $past(I_TOKEN_VALID))
    else $error("token accepted for another address");

    sof_load_a: assert property (
        I_TOKEN_VALID && tok_kind == TOK_SOF |=> frame_q == $past(I_TOKEN_FRAME)
            && !O_TOKEN_ACCEPT)
    else $error("frame index not loaded from start of frame");

    frame_high_a: assert property (
        I_AVS_READ && done && I_AVS_ADDRESS == OFS_FRAME_HI
            |-> O_AVS_READDATA[31:3] == 29'h0000_0000)
    else $error("frame high byte has stray bits");

    disabled_quiet_a: assert property (
        I_TOKEN_VALID && !sel_live |=> !O_TOKEN_ACCEPT && O_HANDSHAKE == HS_NONE)
    else $error("disabled endpoint answered");

    in_only_a: assert property (
        tok_match && sel_setup[BIT_IN_EN] && !sel_setup[BIT_OUT_EN]
            && !sel_setup[BIT_HALT] && tok_kind != TOK_IN |=> !O_TOKEN_ACCEPT)
    else $error("in-only endpoint took other token");

    out_only_a: assert property (
        tok_match && sel_setup[BIT_OUT_EN] && !sel_setup[BIT_IN_EN]
            && !sel_setup[BIT_HALT] && tok_kind != TOK_OUT |=> !O_TOKEN_ACCEPT)
    else $error("out-only endpoint took other token");

    setup_ok_a: assert property (
        tok_match && sel_live && sel_setup[BIT_IN_EN] && sel_setup[BIT_OUT_EN]
            && !sel_setup[BIT_DIR_SEL] && !sel_setup[BIT_HALT]
            |=> O_TOKEN_ACCEPT
            && O_HANDSHAKE == ($past(sel_setup[BIT_ACK_EN]) ? HS_ACK : HS_NONE))
    else $error("bidirectional endpoint refused token");

    stall_wins_a: assert property (
        tok_match && sel_live && sel_setup[BIT_HALT]
            |=> O_TOKEN_ACCEPT && O_HANDSHAKE == HS_STALL
            && O_ACCEPT_ENDP == $past(I_TOKEN_ENDP))
    else $error("halted endpoint did not stall");

    ep_write_a: assert property (
        wr_en && ep_hit && !I_BUS_RESET
            |=> ep_setup_q[$past(ep_sel)] == $past(I_AVS_WRITEDATA[4:0]))
    else $error("endpoint setup write lost");

    wait_once_a: assert property (
        req && !ack_q |-> O_AVS_WAITREQUEST ##1 (!req || !O_AVS_WAITREQUEST))
    else $error("slave waited more than one cycle");

    // Idle bus never stalls, so a master may start at any edge
    wait_idle_a: assert property (
        !req |-> !O_AVS_WAITREQUEST)
    else $error("wait request raised with no request");

    // Read data must stand until the next read is taken
    rd_hold_a: assert property (
        !(I_AVS_READ && !ack_q) |=> $stable(O_AVS_READDATA))
    else $error("read data changed between reads");

    unmapped_zero_a: assert property (
        I_AVS_READ && !ack_q && !ep_hit && I_AVS_ADDRESS != OFS_BUS_ID
            && I_AVS_ADDRESS != OFS_FRAME_LO && I_AVS_ADDRESS != OFS_FRAME_HI
            |=> O_AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read returned data");

    id_hold_a: assert property (
        !I_BUS_RESET && !(wr_en && I_AVS_ADDRESS == OFS_BUS_ID) |=> $stable(bus_id_q))
    else $error("bus id changed without a write");

    // Frame registers are read-only; only a start of frame moves them
    frame_hold_a: assert property (
        !(I_TOKEN_VALID && tok_kind == TOK_SOF) |=> $stable(frame_q))
    else $error("frame index changed without start of frame");

    // Software relies on a clean endpoint set before restoring endpoint zero
    ep_clear_a: assert property (
        I_BUS_RESET |=> ep_setup_q[0] == EP_RST && ep_setup_q[N-1] == EP_RST)
    else $error("endpoint setup survived bus reset");

    hs_idle_a: assert property (
        !O_TOKEN_ACCEPT |-> O_HANDSHAKE == HS_NONE)
    else $error("handshake without accepted token");

    endp_range_a: assert property (
        I_TOKEN_VALID && int'(I_TOKEN_ENDP) >= N |=> !O_TOKEN_ACCEPT)
    else $error("token for missing endpoint accepted");

    accept_info_a: assert property (
        O_TOKEN_ACCEPT |-> O_ACCEPT_ENDP == $past(I_TOKEN_ENDP)
            && O_ACCEPT_KIND == $past(I_TOKEN_KIND))
    else $error("accepted endpoint or kind wrong");

    ack_off_a: assert property (
        tok_match && tok_kind == TOK_OUT && sel_setup[BIT_OUT_EN]
            && !sel_setup[BIT_HALT] && !sel_setup[BIT_ACK_EN]
            |=> O_TOKEN_ACCEPT && O_HANDSHAKE == HS_NONE)
    else $error("handshake sent with acknowledge off");

    sof_seen_c: cover property (I_TOKEN_VALID && tok_kind == TOK_SOF);
    stall_seen_c: cover property (O_TOKEN_ACCEPT && O_HANDSHAKE == HS_STALL);
    zero_pipe_c: cover property (I_BUS_RESET ##[1:200] ep_setup_q[0] == EP_ZERO_DEFAULT);
    setup_taken_c: cover property (O_TOKEN_ACCEPT && O_ACCEPT_KIND == TOK_SETUP);
    id_write_c: cover property (wr_en && I_AVS_ADDRESS == OFS_BUS_ID);

endmodule

// [sim/usb_host_model.sv]
`timescale 1ns/1ps
module usb_host_model
    import usb_ctrl_pkg::*;
(
    input wire logic i_clk,
    output logic o_valid,
    output logic [1:0] o_kind,
    output logic [6:0] o_addr,
    output logic [3:0] o_endp,
    output logic [10:0] o_frame,
    output logic o_bus_reset
);
    initial
    begin
        o_valid = 1'h0;
        o_kind = 2'h0;
        o_addr = 7'h00;
        o_endp = 4'h0;
        o_frame = 11'h000;
        o_bus_reset = 1'h0;
    end

    // Fields inverted between tokens so a stale value never looks valid
    task automatic send(input tok_t kind, input logic [6:0] addr, input logic [3:0] endp,
                        input logic [10:0] frame);
        @(posedge i_clk);
        o_valid <= 1'h1;
        o_kind <= kind;
        o_addr <= addr;
        o_endp <= endp;
        o_frame <= frame;
        @(posedge i_clk);
        o_valid <= 1'h0;
        o_kind <= ~kind;
        o_addr <= ~addr;
        o_endp <= ~endp;
        o_frame <= ~frame;
    endtask

    task automatic bus_reset();
        @(posedge i_clk);
        o_bus_reset <= 1'h1;
        @(posedge i_clk);
        o_bus_reset <= 1'h0;
    endtask
endmodule

// [sim/usb_addr_frame_ep_tb.sv]
`timescale 1ns/1ps
module usb_addr_frame_ep_tb
    import usb_ctrl_pkg::*;
;
    logic clk;
    logic reset_n;
    logic [5:0] address;
    logic rd_req;
    logic wr_req;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic waitreq;
    logic t_valid;
    logic [1:0] t_kind;
    logic [6:0] t_addr;
    logic [3:0] t_endp;
    logic [10:0] t_frame;
    logic bus_rst;
    logic accept;
    logic [1:0] hs;
    logic [3:0] acc_endp;
    logic [1:0] acc_kind;
    logic [31:0] q;
    logic [9:0] row;
    int n_wait = 0;
    int n_errors = 0;
    int n_tests = 0;
    // Row: endpoint setup, token kind, accept, handshake
    logic [9:0] rows [13] = '{
        {5'h00, 2'h1, 1'h0, 2'h0}, {5'h10, 2'h1, 1'h0, 2'h0}, {5'h05, 2'h1, 1'h1, 2'h1},
        {5'h05, 2'h0, 1'h0, 2'h0}, {5'h05, 2'h3, 1'h0, 2'h0}, {5'h09, 2'h0, 1'h1, 2'h1},
        {5'h09, 2'h1, 1'h0, 2'h0}, {5'h0D, 2'h3, 1'h1, 2'h1}, {5'h0D, 2'h1, 1'h1, 2'h1},
        {5'h0C, 2'h0, 1'h1, 2'h0}, {5'h07, 2'h0, 1'h1, 2'h2}, {5'h02, 2'h1, 1'h0, 2'h0},
        {5'h06, 2'h1, 1'h1, 2'h2}};

    usb_addr_frame_ep DUT (.I_SYS_CLK(clk), .I_RESET_N(reset_n), .I_AVS_ADDRESS(address),
        .I_AVS_READ(rd_req), .I_AVS_WRITE(wr_req), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .I_TOKEN_VALID(t_valid), .I_TOKEN_KIND(t_kind), .I_TOKEN_ADDR(t_addr),
        .I_TOKEN_ENDP(t_endp), .I_TOKEN_FRAME(t_frame), .I_BUS_RESET(bus_rst),
        .O_TOKEN_ACCEPT(accept), .O_HANDSHAKE(hs), .O_ACCEPT_ENDP(acc_endp),
        .O_ACCEPT_KIND(acc_kind));

    usb_host_model host (.i_clk(clk), .o_valid(t_valid), .o_kind(t_kind), .o_addr(t_addr),
        .o_endp(t_endp), .o_frame(t_frame), .o_bus_reset(bus_rst));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        n_wait = 0;
        @(posedge clk);
        wr_req <= w;
        rd_req <= ~w;
        address <= a;
        wdata <= d;
        be <= b;
        @(posedge clk);
        // Only the watchdog ends a wait that never finishes
        while (waitreq !== 1'h0)
        begin
            n_wait++;
            @(posedge clk);
        end
        q = rdata;
        wr_req <= 1'h0;
        rd_req <= 1'h0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0000_0000, 4'h1);
        check("register", q, exp);
    endtask

    task automatic tok(input tok_t k, input logic [6:0] a, input logic [3:0] e,
                       input logic exp_acc, input logic [1:0] exp_hs);
        host.send(k, a, e, 11'h000);
        #1;
        check("accept", 32'(accept), 32'(exp_acc));
        check("handshake", 32'(hs), 32'(exp_hs));
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        reset_n = 1'h0;
        address = 6'h00;
        rd_req = 1'h0;
        wr_req = 1'h0;
        wdata = 32'h0000_0000;
        be = 4'h1;
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        rd(OFS_BUS_ID, 32'h0000_0000);
        rd(6'h24, 32'h0000_0000);
        check("wait cycles", n_wait, 32'h0000_0001);
        $display("test reset done");
        // Rows never program the reserved direction combination
        foreach (rows[i])
        begin
            row = rows[i];
            bus(1'h1, 6'h10, 32'(row[9:5]), 4'h1);
            host.send(tok_t'(row[4:3]), 7'h00, 4'h1, 11'h000);
            #1;
            check("accept", 32'(accept), 32'(row[2]));
            check("handshake", 32'(hs), 32'(row[1:0]));
        end
        $display("test endpoint table done");
        bus(1'h1, OFS_BUS_ID, 32'h0000_0035, 4'h1);
        bus(1'h1, OFS_BUS_ID, 32'h0000_0011, 4'h0);
        rd(OFS_BUS_ID, 32'h0000_0035);
        tok(TOK_IN, 7'h00, 4'h1, 1'h0, 2'h0);
        tok(TOK_SOF, 7'h35, 4'h0, 1'h0, 2'h0);
        host.send(TOK_SOF, 7'h35, 4'h0, 11'h5A3);
        rd(OFS_FRAME_LO, 32'h0000_00A3);
        rd(OFS_FRAME_HI, 32'h0000_0005);
        bus(1'h1, OFS_FRAME_LO, 32'h0000_00FF, 4'h1);
        rd(OFS_FRAME_LO, 32'h0000_00A3);
        rd(6'h3C, 32'h0000_0000);
        $display("test address and frame done");
        bus(1'h1, 6'h24, 32'h0000_000D, 4'h1);
        rd(6'h24, 32'h0000_000D);
        tok(TOK_OUT, 7'h35, 4'h6, 1'h1, 2'h1);
        check("accept endpoint", 32'(acc_endp), 32'h0000_0006);
        check("accept kind", 32'(acc_kind), 32'h0000_0000);
        tok(TOK_IN, 7'h35, 4'h7, 1'h0, 2'h0);
        $display("test endpoint range done");
        host.bus_reset();
        rd(OFS_BUS_ID, 32'h0000_0000);
        tok(TOK_OUT, 7'h35, 4'h6, 1'h0, 2'h0);
        bus(1'h1, OFS_EP_BASE, 32'(EP_ZERO_DEFAULT), 4'h1);
        tok(TOK_SETUP, 7'h00, 4'h0, 1'h1, 2'h1);
        $display("test bus reset done");
        // Module reset in mid-run must drop a programmed bus id
        bus(1'h1, OFS_BUS_ID, 32'h0000_0042, 4'h1);
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        rd(OFS_BUS_ID, 32'h0000_0000);
        rd(OFS_EP_BASE, 32'h0000_0000);
        $display("test module reset done");
        stop_test();
    end
endmodule
